// file: hdl/sle_defs.svh
// sle_defs.svh - constants of the safety logic line evaluator
// assumes: included by bare name from every design file that needs it
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SLE_CLK_KHZ        40000
`define SLE_PERIOD_MS      2
`define SLE_PERIOD_CYCLES  (`SLE_PERIOD_MS * `SLE_CLK_KHZ)

// ---------------------------------------------------------------
// program geometry
// ---------------------------------------------------------------
`define SLE_SECTION_LINES  128
`define SLE_TOTAL_LINES    256
`define SLE_LINE_W         8
`define SLE_SRC_W          9
`define SLE_DST_W          8
`define SLE_OPVEC_W        512
`define SLE_AUX_N          128
`define SLE_MS_N           64

// ---------------------------------------------------------------
// operand map (source index space)
// ---------------------------------------------------------------
`define SLE_OP_EXT_ESTOP   0
`define SLE_OP_HOLD        1
`define SLE_OP_PANEL_ESTOP 2
`define SLE_OP_PLAY        3
`define SLE_OP_PEND_ENSW   4
`define SLE_OP_PEND_ESTOP  5
`define SLE_OP_REMOTE      6
`define SLE_OP_PROG_EXTEN  7
`define SLE_OP_PROG_ESTOP  8
`define SLE_OP_PROG_FSPD   9
`define SLE_OP_PROG_FENCE  10
`define SLE_OP_RAW_FENCE   11
`define SLE_OP_SERVO_ON    12
`define SLE_OP_SERVO_RDY   13
`define SLE_OP_TEACH       14
`define SLE_OP_ZERO        15
`define SLE_OP_GPI         16
`define SLE_OP_GPO         32
`define SLE_OP_SFR         48
`define SLE_OP_SPARE       56
`define SLE_OP_FSO         64
`define SLE_OP_MSO         128
`define SLE_OP_LTX         192
`define SLE_OP_LRX         256
`define SLE_OP_SPIN        320
`define SLE_OP_SPARE2      352
`define SLE_OP_AUX         384

// ---------------------------------------------------------------
// destination map: 0..127 relays, 128..191 machine outputs, rest dropped
// ---------------------------------------------------------------
`define SLE_DST_MS_TAG     2'h2

`endif

// file: hdl/sle_pkg.sv
// sle_pkg.sv - types of the safety logic line evaluator
// assumes: compiled before every module of the block
package sle_pkg;

  typedef enum logic [2:0] {
    SLE_NOP  = 3'h0,
    SLE_NOT  = 3'h1,
    SLE_RISE = 3'h2,
    SLE_FALL = 3'h3,
    SLE_AND  = 3'h4,
    SLE_OR   = 3'h5
  } sle_op_t;

  // gray order along idle -> scan -> done
  typedef enum logic [1:0] {
    SLE_IDLE = 2'h0,
    SLE_SCAN = 2'h1,
    SLE_DONE = 2'h3
  } sle_state_t;

endpackage : sle_pkg

// file: hdl/sle_sync.sv
// sle_sync.sv - two flip-flop synchroniser for contact pins
// assumes: inputs are asynchronous levels, clk is the block clock
`timescale 1ns/100ps
`default_nettype none

module sle_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // reset to all zeros: an open contact is the safe reading
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sle_sync

`default_nettype wire

// file: hdl/sle_evaluator.sv
// sle_evaluator.sv - safety logic program evaluator: program store,
// periodic scan of system then user section, operand map, result bank
// assumes: one 40 MHz clock; contact pins are asynchronous, all other
// inputs come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "sle_defs.svh"

module sle_evaluator
  import sle_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = `SLE_PERIOD_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  // contact pins, high = contact closed
  input  wire logic                  ext_estop_closed,
  input  wire logic                  panel_estop_closed,
  input  wire logic                  pendant_estop_closed,
  input  wire logic                  pendant_enable_closed,
  input  wire logic                  raw_fence_closed,
  input  wire logic [15:0]           gp_safe_in_closed,
  // same-clock controller state
  input  wire logic                  hold_req,
  input  wire logic                  mode_teach,
  input  wire logic                  mode_play,
  input  wire logic                  mode_remote,
  input  wire logic                  prog_ext_enable,
  input  wire logic                  prog_ext_estop,
  input  wire logic                  prog_full_speed,
  input  wire logic                  prog_fence,
  input  wire logic                  servo_on_status,
  input  wire logic                  servo_ready_flag,
  input  wire logic [7:0]            servo_onoff_pts,
  input  wire logic [15:0]           gp_safe_out,
  input  wire logic [63:0]           func_safe_out,
  input  wire logic [63:0]           limit_board_tx,
  input  wire logic [63:0]           limit_board_rx,
  input  wire logic [31:0]           spec_in,
  input  wire logic [1:0]            gp_io_fitted,
  input  wire logic [1:0]            limit_board_fitted,
  input  wire logic                  func_safe_enable,
  // program load port
  input  wire logic                  edit_permit,
  input  wire logic                  sys_load_en,
  input  wire logic                  prog_wr_en,
  input  wire logic                  prog_wr_user,
  input  wire logic [6:0]            prog_wr_addr,
  input  wire logic [2:0]            prog_wr_op,
  input  wire logic [`SLE_SRC_W-1:0] prog_wr_src1,
  input  wire logic [`SLE_SRC_W-1:0] prog_wr_src2,
  input  wire logic [`SLE_DST_W-1:0] prog_wr_dst,
  // results and status
  output var  logic                  prog_wr_refused,
  output var  logic [127:0]          aux_relay,
  output var  logic [63:0]           machine_safe_out,
  output logic                       eval_busy,
  output logic                       scan_done,
  output var  logic                  overrun
);

  localparam int unsigned CW = $clog2(PERIOD_CYCLES);

  // ---------------------------------------------------------------
  // contact synchronisers
  // ---------------------------------------------------------------
  logic [20:0] pins_s;

  sle_sync #(.W(21)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({gp_safe_in_closed, raw_fence_closed, pendant_enable_closed,
             pendant_estop_closed, panel_estop_closed, ext_estop_closed}),
    .q     (pins_s)
  );

  // ---------------------------------------------------------------
  // operand map
  // ---------------------------------------------------------------
  logic [`SLE_OPVEC_W-1:0] opvec;
  logic [127:0]            aux_q;
  logic [63:0]             ms_q;
  logic [15:0]             gp_fit16;
  logic [63:0]             lb_fit64;

  assign gp_fit16 = {{8{gp_io_fitted[1]}}, {8{gp_io_fitted[0]}}};
  assign lb_fit64 = {{32{limit_board_fitted[1]}}, {32{limit_board_fitted[0]}}};

  assign opvec[`SLE_OP_EXT_ESTOP]   = ~pins_s[0];
  assign opvec[`SLE_OP_PANEL_ESTOP] = ~pins_s[1];
  assign opvec[`SLE_OP_PEND_ESTOP]  = ~pins_s[2];
  assign opvec[`SLE_OP_PEND_ENSW]   = ~pins_s[3];
  assign opvec[`SLE_OP_RAW_FENCE]   = ~pins_s[4];
  assign opvec[`SLE_OP_HOLD]        = ~hold_req;
  assign opvec[`SLE_OP_PLAY]        = mode_play;
  assign opvec[`SLE_OP_REMOTE]      = mode_remote;
  assign opvec[`SLE_OP_TEACH]       = mode_teach;
  assign opvec[`SLE_OP_PROG_EXTEN]  = prog_ext_enable;
  assign opvec[`SLE_OP_PROG_ESTOP]  = prog_ext_estop;
  assign opvec[`SLE_OP_PROG_FSPD]   = prog_full_speed;
  assign opvec[`SLE_OP_PROG_FENCE]  = prog_fence;
  assign opvec[`SLE_OP_SERVO_ON]    = servo_on_status;
  assign opvec[`SLE_OP_SERVO_RDY]   = servo_ready_flag;
  assign opvec[`SLE_OP_ZERO]        = 1'b0;
  assign opvec[`SLE_OP_GPI +: 16]   = ~pins_s[20:5] & gp_fit16;
  assign opvec[`SLE_OP_GPO +: 16]   = gp_safe_out & gp_fit16;
  assign opvec[`SLE_OP_SFR +: 8]    = servo_onoff_pts;
  assign opvec[`SLE_OP_SPARE +: 8]  = 8'h00;
  assign opvec[`SLE_OP_FSO +: 64]   = func_safe_out & {64{func_safe_enable}};
  assign opvec[`SLE_OP_MSO +: 64]   = ms_q;
  assign opvec[`SLE_OP_LTX +: 64]   = limit_board_tx & lb_fit64;
  assign opvec[`SLE_OP_LRX +: 64]   = limit_board_rx & lb_fit64;
  assign opvec[`SLE_OP_SPIN +: 32]  = spec_in;
  assign opvec[`SLE_OP_SPARE2 +: 32] = 32'h0000_0000;
  assign opvec[`SLE_OP_AUX +: 128]  = aux_q;

  // ---------------------------------------------------------------
  // program store: lines 0..127 system, 128..255 user
  // ---------------------------------------------------------------
  logic [2:0]            op_mem  [`SLE_TOTAL_LINES];
  logic [`SLE_SRC_W-1:0] s1_mem  [`SLE_TOTAL_LINES];
  logic [`SLE_SRC_W-1:0] s2_mem  [`SLE_TOTAL_LINES];
  logic [`SLE_DST_W-1:0] dst_mem [`SLE_TOTAL_LINES];
  logic                  wr_ok;
  logic [7:0]            wr_line;

  // system lines are locked unless a factory load is in progress
  assign wr_ok   = prog_wr_en & (prog_wr_user ? edit_permit : sys_load_en);
  assign wr_line = {prog_wr_user, prog_wr_addr};

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `SLE_TOTAL_LINES; i++) begin
        op_mem[i] <= SLE_NOP;
      end
    end else if (wr_ok) begin
      op_mem[wr_line] <= prog_wr_op;
    end
  end

  // operand fields need no reset: a nop line never reads them
  always_ff @(posedge clk) begin
    if (wr_ok) begin
      s1_mem[wr_line]  <= prog_wr_src1;
      s2_mem[wr_line]  <= prog_wr_src2;
      dst_mem[wr_line] <= prog_wr_dst;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prog_wr_refused <= 1'b0;
    end else begin
      prog_wr_refused <= prog_wr_en & ~wr_ok;
    end
  end

  // ---------------------------------------------------------------
  // period divider and scan sequencer
  // ---------------------------------------------------------------
  logic [CW-1:0] cnt_q;
  logic          tick;
  sle_state_t    st_q;
  logic [7:0]    line_q;

  assign tick = (cnt_q == CW'(PERIOD_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q   <= SLE_IDLE;
      line_q <= 8'h00;
    end else begin
      case (st_q)
        SLE_IDLE: begin
          line_q <= 8'h00;
          if (tick) begin
            st_q <= SLE_SCAN;
          end
        end
        SLE_SCAN: begin
          line_q <= line_q + 8'h01;
          if (line_q == 8'hff) begin
            st_q <= SLE_DONE;
          end
        end
        SLE_DONE: st_q <= SLE_IDLE;
        default:  st_q <= SLE_IDLE;
      endcase
    end
  end

  // a tick while still scanning is dropped; flagged until reset
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun <= 1'b0;
    end else if (tick && st_q != SLE_IDLE) begin
      overrun <= 1'b1;
    end
  end

  assign eval_busy = (st_q == SLE_SCAN);
  assign scan_done = (st_q == SLE_DONE);

  // ---------------------------------------------------------------
  // line execution
  // ---------------------------------------------------------------
  sle_op_t              cur_op;
  logic                 opa;
  logic                 opb;
  logic                 prev_bit;
  logic                 res;
  logic                 exec;
  logic [`SLE_DST_W-1:0] cur_dst;
  logic                 dst_valid;
  logic [`SLE_TOTAL_LINES-1:0] prev_q;

  assign cur_op    = sle_op_t'(op_mem[line_q]);
  assign cur_dst   = dst_mem[line_q];
  assign opa       = opvec[s1_mem[line_q]];
  assign opb       = opvec[s2_mem[line_q]];
  assign prev_bit  = prev_q[line_q];
  assign exec      = eval_busy && (cur_op inside {SLE_NOT, SLE_RISE, SLE_FALL,
                                                 SLE_AND, SLE_OR});
  assign dst_valid = ~cur_dst[7] || (cur_dst[7:6] == `SLE_DST_MS_TAG);

  always_comb begin
    case (cur_op)
      SLE_NOT:  res = ~opa;
      SLE_RISE: res = opa & ~prev_bit;
      SLE_FALL: res = ~opa & prev_bit;
      SLE_AND:  res = opa & opb;
      SLE_OR:   res = opa | opb;
      default:  res = 1'b0;
    endcase
  end

  // edge memory holds each line's operand from the previous period
  // only executing lines update: nop lines carry unwritten operand fields
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= '0;
    end else if (exec) begin
      prev_q[line_q] <= opa;
    end
  end

  // results land at once, so later lines see this period's values
  always_ff @(posedge clk) begin
    if (reset) begin
      aux_q <= '0;
      ms_q  <= '0;
    end else if (exec) begin
      if (!cur_dst[7]) begin
        aux_q[cur_dst[6:0]] <= res;
      end else if (cur_dst[7:6] == `SLE_DST_MS_TAG) begin
        ms_q[cur_dst[5:0]] <= res;
      end
    end
  end

  assign aux_relay        = aux_q;
  assign machine_safe_out = ms_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [`SLE_DST_W-1:0] chk_dst_q;
  logic                  chk_bit;

  always_ff @(posedge clk) begin
    chk_dst_q <= cur_dst;
  end

  assign chk_bit = chk_dst_q[7] ? ms_q[chk_dst_q[5:0]] : aux_q[chk_dst_q[6:0]];

  sequence s_exec(sle_op_t o);
    exec && dst_valid && cur_op == o;
  endsequence

  a_not_invert: assert property (@(posedge clk) disable iff (reset)
    s_exec(SLE_NOT) |=> chk_bit == !$past(opa))
    else $error("invert result not stored");
  a_rise_pulse: assert property (@(posedge clk) disable iff (reset)
    s_exec(SLE_RISE) |=> chk_bit == ($past(opa) && !$past(prev_bit)))
    else $error("rising edge result wrong");
  a_fall_pulse: assert property (@(posedge clk) disable iff (reset)
    s_exec(SLE_FALL) |=> chk_bit == (!$past(opa) && $past(prev_bit)))
    else $error("falling edge result wrong");
  a_and_or: assert property (@(posedge clk) disable iff (reset)
    (s_exec(SLE_AND) |=> chk_bit == ($past(opa) && $past(opb))) and
    (s_exec(SLE_OR) |=> chk_bit == ($past(opa) || $past(opb))))
    else $error("and/or result wrong");
  a_scan_length: assert property (@(posedge clk) disable iff (reset)
    (st_q == SLE_IDLE && tick) |=> eval_busy [*8] ##249 scan_done)
    else $error("scan did not cover 256 lines");
  a_estop_sense: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2)) |->
      opvec[`SLE_OP_EXT_ESTOP] == !$past(ext_estop_closed, 2))
    else $error("external stop operand polarity");
  a_absent_off: assert property (@(posedge clk) disable iff (reset)
    (!gp_io_fitted[0] |-> opvec[`SLE_OP_GPI +: 8] == 8'h00) and
    (!gp_io_fitted[1] |-> opvec[`SLE_OP_GPI + 8 +: 8] == 8'h00))
    else $error("absent board input reads on");
  a_hold_sense: assert property (@(posedge clk) disable iff (reset)
    $rose(hold_req) |-> !opvec[`SLE_OP_HOLD] && $past(opvec[`SLE_OP_HOLD]))
    else $error("hold operand polarity");

endmodule : sle_evaluator

`default_nettype wire

// file: bench/sle_contact_model.sv
// sle_contact_model.sv - contacts and optional safety i/o boards at the pins
// assumes: bench drives the open requests at clk rising edge
`timescale 1ns/100ps
`default_nettype none

module sle_contact_model (
  input  wire logic        clk,
  input  wire logic [4:0]  stop_open,
  input  wire logic [15:0] gp_open,
  input  wire logic [1:0]  gp_fit,
  output var  logic        ext_estop_closed,
  output var  logic        panel_estop_closed,
  output var  logic        pendant_estop_closed,
  output var  logic        pendant_enable_closed,
  output var  logic        raw_fence_closed,
  output var  logic [15:0] gp_safe_in_closed,
  output var  logic [1:0]  gp_io_fitted
);
  logic tgl_q = 1'b0;

  // a contact reads high while closed, so open maps to low
  // plain always: the toggle keeps its declared start value
  always @(posedge clk) begin
    tgl_q <= ~tgl_q;
    {ext_estop_closed, panel_estop_closed, pendant_estop_closed} <= ~stop_open[4:2];
    pendant_enable_closed <= ~stop_open[1];
    raw_fence_closed <= ~stop_open[0];
    gp_io_fitted <= gp_fit;
    // pins of a missing board float: churn them so masking is exercised
    gp_safe_in_closed[7:0] <= gp_fit[0] ? ~gp_open[7:0] : {8{tgl_q}};
    gp_safe_in_closed[15:8] <= gp_fit[1] ? ~gp_open[15:8] : {8{tgl_q}};
  end
endmodule : sle_contact_model
`default_nettype wire

// file: bench/testbench.sv
// testbench.sv - self-checking bench of the safety logic line evaluator
// assumes: sle_pkg, sle_defs.svh and the design files are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module testbench;
  import sle_pkg::*;
  localparam int unsigned PER = 300;
  typedef struct packed {
    logic [2:0] op;
    logic [8:0] a;
    logic [8:0] b;
    logic [7:0] d;
    logic       e;
  } sle_row_t;
  logic        clk, reset, ext_c, panel_c, pend_c, pen_c, fence_c, r;
  logic [4:0]  stop_open;
  logic [15:0] gp_open, gpi_c, gp_out;
  logic [1:0]  gp_fit, gp_io_fitted, lb_fit;
  logic        hold_req, teach, play, remote, p_en, p_es, p_fs, p_fence, sv_on, sv_rdy;
  logic [7:0]  sv_pts, dst;
  logic [63:0] fso, ltx, lrx, mso;
  logic [31:0] spec;
  logic        fs_en, edit_permit, sys_load_en, wr_en, wr_user, refused, busy, done, ovr;
  logic [6:0]  wr_addr;
  logic [2:0]  wr_op;
  logic [8:0]  s1, s2;
  logic [127:0] aux;
  int          failures, cmp_count, n, nb;
  // ------------------------------------------------------------
  // ordinary cases: one user line each, inputs fixed below
  // ------------------------------------------------------------
  sle_row_t rows [18] = '{
    '{SLE_NOT, 9'h000, 9'h00f, 8'h00, 1'h0},
    '{SLE_OR,  9'h001, 9'h00f, 8'h01, 1'h0},
    '{SLE_OR,  9'h002, 9'h005, 8'h02, 1'h1},
    '{SLE_AND, 9'h002, 9'h005, 8'h03, 1'h0},
    '{SLE_NOT, 9'h004, 9'h00f, 8'h04, 1'h1},
    '{SLE_OR,  9'h00e, 9'h006, 8'h05, 1'h0},
    '{SLE_AND, 9'h003, 9'h007, 8'h06, 1'h1},
    '{SLE_OR,  9'h008, 9'h00a, 8'h07, 1'h0},
    '{SLE_AND, 9'h009, 9'h00b, 8'h08, 1'h1},
    '{SLE_AND, 9'h00c, 9'h010, 8'h09, 1'h1},
    '{SLE_OR,  9'h018, 9'h00f, 8'h0a, 1'h0},
    '{SLE_AND, 9'h020, 9'h034, 8'h0b, 1'h1},
    '{SLE_OR,  9'h040, 9'h0c0, 8'h0c, 1'h0},
    '{SLE_AND, 9'h120, 9'h15f, 8'h0d, 1'h1},
    '{SLE_NOT, 9'h00d, 9'h00f, 8'h0e, 1'h0},
    '{SLE_OR,  9'h000, 9'h00f, 8'h80, 1'h1},
    '{SLE_OR,  9'h080, 9'h00f, 8'h10, 1'h1},
    '{SLE_OR,  9'h186, 9'h00f, 8'h11, 1'h1}
  };

  sle_contact_model sle_contact_model_i (.clk(clk), .stop_open(stop_open),
    .gp_open(gp_open), .gp_fit(gp_fit), .ext_estop_closed(ext_c),
    .panel_estop_closed(panel_c), .pendant_estop_closed(pend_c),
    .pendant_enable_closed(pen_c), .raw_fence_closed(fence_c),
    .gp_safe_in_closed(gpi_c), .gp_io_fitted(gp_io_fitted));

  sle_evaluator #(.PERIOD_CYCLES(PER)) sle_evaluator_i (.clk(clk), .reset(reset),
    .ext_estop_closed(ext_c), .panel_estop_closed(panel_c), .pendant_estop_closed(pend_c),
    .pendant_enable_closed(pen_c), .raw_fence_closed(fence_c), .gp_safe_in_closed(gpi_c),
    .hold_req(hold_req), .mode_teach(teach), .mode_play(play), .mode_remote(remote),
    .prog_ext_enable(p_en), .prog_ext_estop(p_es), .prog_full_speed(p_fs),
    .prog_fence(p_fence), .servo_on_status(sv_on), .servo_ready_flag(sv_rdy),
    .servo_onoff_pts(sv_pts), .gp_safe_out(gp_out), .func_safe_out(fso),
    .limit_board_tx(ltx), .limit_board_rx(lrx), .spec_in(spec),
    .gp_io_fitted(gp_io_fitted), .limit_board_fitted(lb_fit), .func_safe_enable(fs_en),
    .edit_permit(edit_permit), .sys_load_en(sys_load_en), .prog_wr_en(wr_en),
    .prog_wr_user(wr_user), .prog_wr_addr(wr_addr), .prog_wr_op(wr_op),
    .prog_wr_src1(s1), .prog_wr_src2(s2), .prog_wr_dst(dst), .prog_wr_refused(refused),
    .aux_relay(aux), .machine_safe_out(mso), .eval_busy(busy), .scan_done(done),
    .overrun(ovr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic bitof(input logic [7:0] d);
    return d[7] ? mso[d[5:0]] : aux[d[6:0]];
  endfunction : bitof

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // one line per write, then an idle cycle before the next strobe
  task automatic wr(input logic u, input logic [6:0] ad, input logic [2:0] op,
                    input logic [8:0] a, input logic [7:0] d, output logic rf);
    wr_user <= u;
    wr_addr <= ad;
    wr_op <= op;
    s1 <= a;
    s2 <= 9'h00f;
    dst <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 rf = refused;
    @(posedge clk);
  endtask : wr

  task automatic wait_scan();
    // a whole period plus a scan can pass before the next end
    for (int i = 0; i < 2 * PER; i++) begin
      @(posedge clk);
      if (done === 1'b1) return;
    end
    failures++;
    $display("[FAIL] %0t no scan end", $time);
    complete_run();
  endtask : wait_scan

  initial begin
    reset = 1'b1;
    {stop_open, gp_open, gp_fit} = {5'h15, 16'h0101, 2'h1};
    {hold_req, teach, play, remote, p_en, p_es, p_fs, p_fence, sv_on, sv_rdy} = 10'h2ab;
    {sv_pts, gp_out, fso, ltx, lrx} = {8'h10, 16'h0001, 64'h1, 64'h1, 64'h1_0000_0001};
    {spec, lb_fit, fs_en} = {32'h8000_0000, 2'h2, 1'h0};
    {edit_permit, sys_load_en, wr_en, wr_user, wr_addr, wr_op, s1, s2, dst} = '0;
    edit_permit = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 `CHK({aux, mso, busy, done, ovr, refused}, 196'h0)
    $display("test reset done");
    foreach (rows[i]) wr(1'b1, 7'(i), rows[i].op, rows[i].a, rows[i].d, r);
    foreach (rows[i]) begin
      s2 <= rows[i].b;
      wr_user <= 1'b1;
      wr_addr <= 7'(i);
      wr_op <= rows[i].op;
      s1 <= rows[i].a;
      dst <= rows[i].d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
    end
    wait_scan();
    wait_scan();
    foreach (rows[i]) `CHK(bitof(rows[i].d), rows[i].e)
    $display("test table done");
    // ------------------------------------------------------------
    // awkward cases
    // ------------------------------------------------------------
    n = 0;
    nb = 0;
    // done still reads high in this step, so count edges until it shows again
    for (int i = 0; i < 2 * PER; i++) begin
      @(posedge clk);
      n++;
      if (busy === 1'b1) nb++;
      if (done === 1'b1) break;
    end
    `CHK(n, PER)
    `CHK(nb, 256)
    $display("test period done");
    wr(1'b1, 7'h28, SLE_RISE, 9'h006, 8'h28, r);
    wr(1'b1, 7'h29, SLE_FALL, 9'h006, 8'h29, r);
    wait_scan();
    wait_scan();
    `CHK(aux[41:40], 2'h0)
    remote <= 1'b1;
    wait_scan();
    `CHK(aux[41:40], 2'h1)
    wait_scan();
    `CHK(aux[41:40], 2'h0)
    remote <= 1'b0;
    wait_scan();
    `CHK(aux[41:40], 2'h2)
    wait_scan();
    `CHK(aux[41:40], 2'h0)
    hold_req <= 1'b0;
    wait_scan();
    `CHK(aux[1], 1'b1)
    hold_req <= 1'b1;
    $display("test edges done");
    edit_permit <= 1'b0;
    wr(1'b1, 7'h00, SLE_NOT, 9'h001, 8'h00, r);
    `CHK(r, 1'b1)
    wr(1'b0, 7'h05, SLE_NOT, 9'h00f, 8'h14, r);
    `CHK(r, 1'b1)
    edit_permit <= 1'b1;
    sys_load_en <= 1'b1;
    wr(1'b0, 7'h05, SLE_NOT, 9'h00f, 8'h14, r);
    `CHK(r, 1'b0)
    wr(1'b1, 7'h7f, SLE_NOT, 9'h00f, 8'h15, r);
    wait_scan();
    wait_scan();
    `CHK({aux[21:20], aux[0]}, 3'h6)
    `CHK(ovr, 1'b0)
    $display("test sections done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK({aux, mso}, 192'h0)
    $display("test second reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
